// >>> rtl/dual_timer_pkg.sv
/*
 * Constants and types for the dual timer/counter block.
 * Assumes one 40 MHz system clock and a simple strobe register port.
 */
`default_nettype none
package dual_timer_pkg;
	// -------------------------------------------------
	// register map
	// -------------------------------------------------
	localparam logic [2:0] ADDR_MODE    = 3'h0;
	localparam logic [2:0] ADDR_CTRL    = 3'h1;
	localparam logic [2:0] ADDR_LOW0    = 3'h2;
	localparam logic [2:0] ADDR_HIGH0   = 3'h3;
	localparam logic [2:0] ADDR_LOW1    = 3'h4;
	localparam logic [2:0] ADDR_HIGH1   = 3'h5;
	localparam logic [2:0] ADDR_IRQ_ST  = 3'h6;
	localparam logic [2:0] ADDR_IRQ_MSK = 3'h7;
	// -------------------------------------------------
	// field positions
	// -------------------------------------------------
	localparam int MODE1_LSB    = 4;
	localparam int MODE0_LSB    = 0;
	localparam int CTRL_OVF1    = 7;
	localparam int CTRL_RUN1    = 6;
	localparam int CTRL_OVF0    = 5;
	localparam int CTRL_RUN0    = 4;
	localparam int IRQ_OVF0     = 0;
	localparam int IRQ_OVF1     = 1;
	localparam int IRQ_EXT0     = 2;
	localparam int IRQ_EXT1     = 3;
	// -------------------------------------------------
	// reset values
	// -------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_NIB  = 4'h0;
	localparam logic [3:0] RST_PINS = 4'hF;
	// -------------------------------------------------
	// timing
	// -------------------------------------------------
	localparam int OSC_PER_MCYC   = 12;
	localparam int OSC_PER_MCYC_F = 6;
	localparam logic [3:0] DIV_LAST    = 4'(OSC_PER_MCYC - 1);
	localparam logic [3:0] DIV_LAST_F  = 4'(OSC_PER_MCYC_F - 1);
	localparam logic [4:0] LOW5_MAX    = 5'h1F;
	localparam logic [7:0] BYTE_MAX    = 8'hFF;
	// -------------------------------------------------
	// types
	// -------------------------------------------------
	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_RELOAD,
		MODE_SPLIT
	} tmode_t;
	typedef struct packed {
		logic   gate;
		logic   ext_src;
		tmode_t mode;
	} tcfg_t;
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} tcount_t;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} regreq_t;
endpackage
`default_nettype wire

// >>> rtl/dual_timer_counter.sv
/*
 * Two up-counting timer/counters with mode and control registers,
 * sticky interrupt status and a baud pulse from timer 1.
 * Assumes pins are asynchronous and the register master never waits.
 */
// Design decisions made here: the register addresses and the strobed register port.
// Operation
// - each counter picks one of four modes by its two-bit field
// - mode 0 uses 8 high bits and low five bits, 13 bits
// - overflow from all ones sets the flag and requests an interrupt, except timer 1 while timer 0 is in mode 3
// - counting enabled when run set and gate clear or irq pin high
// - setting the run bit never clears the count
// - mode 1 is mode 0 with the full sixteen bits
// - timer 0 mode 2 counts low byte, reloads it from high byte
// - timer 0 mode 3 high byte is timer using timer 1 run and flag
// - timer 1 in mode 3 stops counting
// - timer 1 mode 2 reserved, no reload, counter holds
// - each timer 1 overflow gives a pulse to the serial port
// - source is machine cycle tick, or count pin when select set
// - gating leaves the irq pin low-level interrupt untouched
// - mode and control writes take effect at end of the access
// - two 8-bit config registers: mode has timer 1 high nibble, timer 0 low; control has both in high nibble
// - count pin sampled per machine cycle, one-then-zero counts
// - timer counts once per machine cycle of twelve oscillator cycles, or six when fast tick set
`default_nettype none
module dual_timer_counter (
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	// register port
	input  wire logic [2:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// pins
	input  wire logic       count_pin_zero_i,
	input  wire logic       count_pin_one_i,
	input  wire logic       ext_irq_pin_zero_i,
	input  wire logic       ext_irq_pin_one_i,
	// events
	input  wire logic       fast_tick_i,
	output logic            baud_pulse_o,
	output logic            irq_o
);
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	dual_timer_pkg::regreq_t req;
	dual_timer_pkg::tcfg_t   cfg0;
	dual_timer_pkg::tcfg_t   cfg1;
	dual_timer_pkg::tcount_t cnt0_ff;
	dual_timer_pkg::tcount_t cnt1_ff;
	dual_timer_pkg::tcount_t nxt_cnt0;
	dual_timer_pkg::tcount_t nxt_cnt1;
	logic [7:0] mode_ff;
	logic [7:0] ctrl_ff;
	logic [7:0] nxt_ctrl;
	logic [3:0] irq_st_ff;
	logic [3:0] irq_msk_ff;
	logic [3:0] nxt_irq_st;
	logic [3:0] div_ff;
	logic [3:0] pin_s1_ff;
	logic [3:0] pin_s2_ff;
	logic [1:0] cnt_smp_ff;
	logic [7:0] rdata_ff;
	logic       baud_ff;
	logic       mcyc;
	logic       en0;
	logic       en1;
	logic       inc0;
	logic       inc1;
	logic       inc_high0;
	logic       ovf0;
	logic       ovf1;
	logic       ovf_split;
	logic       ovf_t1_flag;
	logic       fall0;
	logic       fall1;
	logic       wr_ctrl;
	logic       rd_status;
	logic [7:0] rd_mux;
	logic [3:0] events;

	assign req  = '{addr: reg_addr_i, wdata: reg_wdata_i,
	                wr: reg_wr_i, rd: reg_rd_i};
	assign cfg0 = dual_timer_pkg::tcfg_t'(
		mode_ff[dual_timer_pkg::MODE0_LSB +: 4]);
	assign cfg1 = dual_timer_pkg::tcfg_t'(
		mode_ff[dual_timer_pkg::MODE1_LSB +: 4]);

	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	// count source: pin fall or machine-cycle tick
	function automatic logic src_tick(input logic ext, input logic fall,
		input logic tick);
		src_tick = ext ? fall : tick;
	endfunction
	function automatic logic gate_ok(input logic run, input logic gate,
		input logic pin);
		gate_ok = run && (!gate || pin);
	endfunction
	// 13/16-bit increment; returns overflow via output
	function automatic dual_timer_pkg::tcount_t step_wide(
		input dual_timer_pkg::tcount_t c, input logic wide,
		output logic ovf);
		logic [4:0] lo5;
		dual_timer_pkg::tcount_t r;
		lo5 = c.low[4:0];
		r   = c;
		ovf = 1'b0;
		if (wide) begin
			r   = dual_timer_pkg::tcount_t'(16'({c.high, c.low} + 16'h0001));
			ovf = ({c.high, c.low} == 16'hFFFF);
		end else begin
			r.low[4:0] = 5'(lo5 + 5'h01);
			if (lo5 == dual_timer_pkg::LOW5_MAX) begin
				r.high = 8'(c.high + 8'h01);
			end
			ovf = (lo5 == dual_timer_pkg::LOW5_MAX) &&
			      (c.high == dual_timer_pkg::BYTE_MAX);
		end
		step_wide = r;
	endfunction

	// ---------------------------------------------------------------
	// synchronisers and machine-cycle divider
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			// idle high, so leaving reset raises no false irq event
			pin_s1_ff <= dual_timer_pkg::RST_PINS;
			pin_s2_ff <= dual_timer_pkg::RST_PINS;
		end else begin
			pin_s1_ff <= {ext_irq_pin_one_i, ext_irq_pin_zero_i,
			              count_pin_one_i, count_pin_zero_i};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// one machine cycle is twelve clocks, or six when fast tick set
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_ff <= dual_timer_pkg::RST_NIB;
		end else if (mcyc) begin
			div_ff <= dual_timer_pkg::RST_NIB;
		end else begin
			div_ff <= 4'(div_ff + 4'h1);
		end
	end
	assign mcyc = fast_tick_i ? (div_ff >= dual_timer_pkg::DIV_LAST_F)
	                          : (div_ff == dual_timer_pkg::DIV_LAST);

	// pin sampled once per machine cycle; 1 then 0 is one count
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_smp_ff <= 2'h0;
		end else if (mcyc) begin
			cnt_smp_ff <= pin_s2_ff[1:0];
		end
	end
	assign fall0 = mcyc && cnt_smp_ff[0] && !pin_s2_ff[0];
	assign fall1 = mcyc && cnt_smp_ff[1] && !pin_s2_ff[1];

	// ---------------------------------------------------------------
	// count enables
	// ---------------------------------------------------------------
	assign en0 = gate_ok(ctrl_ff[dual_timer_pkg::CTRL_RUN0], cfg0.gate,
	                     pin_s2_ff[2]);
	assign en1 = gate_ok(ctrl_ff[dual_timer_pkg::CTRL_RUN1], cfg1.gate,
	                     pin_s2_ff[3]);
	assign inc0 = en0 && src_tick(cfg0.ext_src, fall0, mcyc);
	// split high byte: machine cycles, run bit one only
	assign inc_high0 = (cfg0.mode == dual_timer_pkg::MODE_SPLIT) &&
	                   ctrl_ff[dual_timer_pkg::CTRL_RUN1] && mcyc;
	// timer 1 idles in mode 3 and in its reserved reload mode
	assign inc1 = en1 && src_tick(cfg1.ext_src, fall1, mcyc) &&
	              (cfg1.mode != dual_timer_pkg::MODE_SPLIT) &&
	              (cfg1.mode != dual_timer_pkg::MODE_RELOAD);

	// ---------------------------------------------------------------
	// counter next state
	// ---------------------------------------------------------------
	always_comb begin
		nxt_cnt0  = cnt0_ff;
		ovf0      = 1'b0;
		ovf_split = 1'b0;
		case (cfg0.mode)
			dual_timer_pkg::MODE_13BIT,
			dual_timer_pkg::MODE_16BIT: begin
				if (inc0) begin
					nxt_cnt0 = step_wide(cnt0_ff,
						cfg0.mode == dual_timer_pkg::MODE_16BIT, ovf0);
				end
			end
			dual_timer_pkg::MODE_RELOAD: begin
				if (inc0) begin
					ovf0 = (cnt0_ff.low == dual_timer_pkg::BYTE_MAX);
					nxt_cnt0.low = ovf0 ? cnt0_ff.high
					                    : 8'(cnt0_ff.low + 8'h01);
				end
			end
			default: begin
				if (inc0) begin
					ovf0 = (cnt0_ff.low == dual_timer_pkg::BYTE_MAX);
					nxt_cnt0.low = 8'(cnt0_ff.low + 8'h01);
				end
				if (inc_high0) begin
					ovf_split = (cnt0_ff.high == dual_timer_pkg::BYTE_MAX);
					nxt_cnt0.high = 8'(cnt0_ff.high + 8'h01);
				end
			end
		endcase
		// software writes of count bytes override the increment
		if (req.wr && req.addr == dual_timer_pkg::ADDR_LOW0) begin
			nxt_cnt0.low = req.wdata;
		end
		if (req.wr && req.addr == dual_timer_pkg::ADDR_HIGH0) begin
			nxt_cnt0.high = req.wdata;
		end
	end

	always_comb begin
		nxt_cnt1 = cnt1_ff;
		ovf1     = 1'b0;
		if (inc1) begin
			nxt_cnt1 = step_wide(cnt1_ff,
				cfg1.mode == dual_timer_pkg::MODE_16BIT, ovf1);
		end
		if (req.wr && req.addr == dual_timer_pkg::ADDR_LOW1) begin
			nxt_cnt1.low = req.wdata;
		end
		if (req.wr && req.addr == dual_timer_pkg::ADDR_HIGH1) begin
			nxt_cnt1.high = req.wdata;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt0_ff <= '0;
			cnt1_ff <= '0;
		end else begin
			cnt0_ff <= nxt_cnt0;
			cnt1_ff <= nxt_cnt1;
		end
	end

	// ---------------------------------------------------------------
	// mode and control registers
	// ---------------------------------------------------------------
	// overflow of timer 1 flag comes from split high byte in mode 3
	assign ovf_t1_flag = (cfg0.mode == dual_timer_pkg::MODE_SPLIT) ?
	                     ovf_split : ovf1;
	assign wr_ctrl     = req.wr && req.addr == dual_timer_pkg::ADDR_CTRL;
	always_comb begin
		nxt_ctrl = wr_ctrl ? req.wdata : ctrl_ff;
		// hardware set wins over a same-cycle software clear
		if (ovf0) begin
			nxt_ctrl[dual_timer_pkg::CTRL_OVF0] = 1'b1;
		end
		if (ovf_t1_flag) begin
			nxt_ctrl[dual_timer_pkg::CTRL_OVF1] = 1'b1;
		end
	end
	// writes land at the clock edge closing the access
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			mode_ff <= dual_timer_pkg::RST_BYTE;
			ctrl_ff <= dual_timer_pkg::RST_BYTE;
		end else begin
			if (req.wr && req.addr == dual_timer_pkg::ADDR_MODE) begin
				mode_ff <= req.wdata;
			end
			ctrl_ff <= nxt_ctrl;
		end
	end

	// ---------------------------------------------------------------
	// interrupt status, mask and baud pulse
	// ---------------------------------------------------------------
	// irq pins request while low, independent of gating
	assign events = {!pin_s2_ff[3], !pin_s2_ff[2],
	                 ovf_t1_flag, ovf0};
	assign rd_status = req.rd && req.addr == dual_timer_pkg::ADDR_IRQ_ST;
	assign nxt_irq_st = (rd_status ? 4'h0 : irq_st_ff) | events;
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_st_ff  <= dual_timer_pkg::RST_NIB;
			irq_msk_ff <= dual_timer_pkg::RST_NIB;
			baud_ff    <= 1'b0;
		end else begin
			irq_st_ff <= nxt_irq_st;
			if (req.wr && req.addr == dual_timer_pkg::ADDR_IRQ_MSK) begin
				irq_msk_ff <= req.wdata[3:0];
			end
			baud_ff <= ovf1;
		end
	end
	assign irq_o        = |(irq_st_ff & irq_msk_ff);
	assign baud_pulse_o = baud_ff;

	// ---------------------------------------------------------------
	// read back
	// ---------------------------------------------------------------
	assign rd_mux =
		(req.addr == dual_timer_pkg::ADDR_MODE)   ? mode_ff :
		(req.addr == dual_timer_pkg::ADDR_CTRL)   ? ctrl_ff :
		(req.addr == dual_timer_pkg::ADDR_LOW0)   ? cnt0_ff.low :
		(req.addr == dual_timer_pkg::ADDR_HIGH0)  ? cnt0_ff.high :
		(req.addr == dual_timer_pkg::ADDR_LOW1)   ? cnt1_ff.low :
		(req.addr == dual_timer_pkg::ADDR_HIGH1)  ? cnt1_ff.high :
		(req.addr == dual_timer_pkg::ADDR_IRQ_ST) ? {4'h0, irq_st_ff} :
		{4'h0, irq_msk_ff};
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_ff <= dual_timer_pkg::RST_BYTE;
		end else if (req.rd) begin
			rdata_ff <= rd_mux;
		end
	end
	assign reg_rdata_o = rdata_ff;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_ovf0_flag;
		@(posedge sys_clk_i) disable iff (reset_i)
		ovf0 |=> ctrl_ff[dual_timer_pkg::CTRL_OVF0];
	endproperty
	a_ovf0_flag: assert property (p_ovf0_flag)
		else $error("overflow 0 did not set flag");
	property p_no_run_hold;
		@(posedge sys_clk_i) disable iff (reset_i)
		(!ctrl_ff[dual_timer_pkg::CTRL_RUN1] && !req.wr)
		|=> $stable(cnt1_ff);
	endproperty
	a_no_run_hold: assert property (p_no_run_hold)
		else $error("timer 1 counted while stopped");
	property p_t1_mode3_stop;
		@(posedge sys_clk_i) disable iff (reset_i)
		(cfg1.mode == dual_timer_pkg::MODE_SPLIT && !req.wr)
		|=> $stable(cnt1_ff);
	endproperty
	a_t1_mode3_stop: assert property (p_t1_mode3_stop)
		else $error("timer 1 counted in mode 3");
	property p_reload;
		@(posedge sys_clk_i) disable iff (reset_i)
		(cfg0.mode == dual_timer_pkg::MODE_RELOAD && ovf0 && !req.wr)
		|=> cnt0_ff.low == $past(cnt0_ff.high) && $stable(cnt0_ff.high);
	endproperty
	a_reload: assert property (p_reload)
		else $error("low byte not reloaded from high byte");
	property p_baud;
		@(posedge sys_clk_i) disable iff (reset_i)
		ovf1 |=> baud_pulse_o ##1 !baud_pulse_o || $past(ovf1);
	endproperty
	a_baud: assert property (p_baud)
		else $error("baud pulse missing after timer 1 overflow");
	property p_mcyc_spacing;
		@(posedge sys_clk_i) disable iff (reset_i)
		(mcyc && !fast_tick_i) |=> !mcyc [*5];
	endproperty
	a_mcyc_spacing: assert property (p_mcyc_spacing)
		else $error("machine cycle tick too close");
	property p_run_keeps;
		@(posedge sys_clk_i) disable iff (reset_i)
		(wr_ctrl && !inc0 && !inc_high0 &&
		 req.addr != dual_timer_pkg::ADDR_LOW0) |=> $stable(cnt0_ff);
	endproperty
	a_run_keeps: assert property (p_run_keeps)
		else $error("control write changed count");
	property p_mode0_width;
		@(posedge sys_clk_i) disable iff (reset_i)
		(cfg0.mode == dual_timer_pkg::MODE_13BIT && inc0 &&
		 cnt0_ff.low[4:0] == 5'h1F && cnt0_ff.high == 8'hFF)
		|-> ovf0;
	endproperty
	a_mode0_width: assert property (p_mode0_width)
		else $error("13 bit overflow missed");
	property p_fall_needs_high;
		@(posedge sys_clk_i) disable iff (reset_i)
		(cfg0.ext_src && cfg0.mode == dual_timer_pkg::MODE_16BIT &&
		 en0 && fall0 && !req.wr)
		|=> {cnt0_ff.high, cnt0_ff.low} ==
		    16'({$past(cnt0_ff.high), $past(cnt0_ff.low)} + 16'h0001);
	endproperty
	a_fall_needs_high: assert property (p_fall_needs_high)
		else $error("pin fall did not count in the next cycle");
endmodule
`default_nettype wire

// >>> verification/pin_source.sv
/*
 * Behavioural source for the external count and gate/irq pins.
 * Assumes the bench calls its tasks and shares the system clock.
 */
`default_nettype none
module pin_source (
	// clock
	input  wire logic sys_clk_i,
	// pins
	output logic      count_pin_zero_o,
	output logic      count_pin_one_o,
	output logic      ext_irq_pin_zero_o,
	output logic      ext_irq_pin_one_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// -------------------------------------------------
	// pin drive
	// -------------------------------------------------
	// two machine cycles per level, margin for the 2-ff sync
	localparam int HOLD_CLKS = 24;
	initial begin
		count_pin_zero_o   = 1'b1;
		count_pin_one_o    = 1'b1;
		ext_irq_pin_zero_o = 1'b1;
		ext_irq_pin_one_o  = 1'b1;
	end
	task automatic pulses(input int which, input int n);
		for (int i = 0; i < 2 * n; i++) begin
			@(posedge sys_clk_i);
			if (which == 0)
				count_pin_zero_o <= ~count_pin_zero_o;
			else
				count_pin_one_o <= ~count_pin_one_o;
			repeat (HOLD_CLKS - 1) @(posedge sys_clk_i);
		end
	endtask
	task automatic gate(input int which, input logic level);
		@(posedge sys_clk_i);
		if (which == 0)
			ext_irq_pin_zero_o <= level;
		else
			ext_irq_pin_one_o <= level;
	endtask
endmodule
`default_nettype wire

// >>> verification/dual_timer_counter_test.sv
/*
 * Self-checking bench for the dual timer/counter.
 * Assumes the pin_source model drives all four pins.
 */
`default_nettype none
module dual_timer_counter_test;
	timeunit 1ns;
	timeprecision 100ps;
	// -------------------------------------------------
	// signals
	// -------------------------------------------------
	logic       sys_clk_i;
	logic       reset_i;
	logic [2:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	logic       reg_wr_i;
	logic       reg_rd_i;
	logic [7:0] reg_rdata_o;
	logic       fast_tick_i;
	logic       baud_pulse_o;
	logic       irq_o;
	wire        cnt0;
	wire        cnt1;
	wire        irq0;
	wire        irq1;
	int         mismatches;
	int         check_count;
	int         baud_count;
	dual_timer_counter dut (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.count_pin_zero_i(cnt0), .count_pin_one_i(cnt1),
		.ext_irq_pin_zero_i(irq0), .ext_irq_pin_one_i(irq1),
		.fast_tick_i(fast_tick_i), .baud_pulse_o(baud_pulse_o),
		.irq_o(irq_o)
	);
	pin_source pins (
		.sys_clk_i(sys_clk_i),
		.count_pin_zero_o(cnt0), .count_pin_one_o(cnt1),
		.ext_irq_pin_zero_o(irq0), .ext_irq_pin_one_o(irq1)
	);
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	always @(negedge sys_clk_i)
		if (baud_pulse_o === 1'b1)
			baud_count++;
	// -------------------------------------------------
	// helpers
	// -------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic check_in(input logic [7:0] seen, input int lo,
			input int hi);
		check((seen >= lo && seen <= hi) ? 8'h01 : 8'h00, 8'h01);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i    <= 1'b0;
	endtask
	// data appear in the cycle after the strobe and hold until the next read
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i   <= 1'b0;
		#1 d = reg_rdata_o;
	endtask
	task automatic wait_flag(input int pos);
		logic [7:0] v;
		for (int i = 0; i < 300; i++) begin
			rd(dual_timer_pkg::ADDR_CTRL, v);
			if (v[pos] === 1'b1)
				return;
		end
		mismatches++;
		$display("MISMATCH at %0t: overflow flag never set", $time);
		complete_run();
	endtask
	task automatic load0(input logic [7:0] m, input logic [7:0] lo,
			input logic [7:0] hi);
		wr(dual_timer_pkg::ADDR_CTRL, 8'h00);
		wr(dual_timer_pkg::ADDR_MODE, m);
		wr(dual_timer_pkg::ADDR_LOW0, lo);
		wr(dual_timer_pkg::ADDR_HIGH0, hi);
	endtask
	// -------------------------------------------------
	// scenarios
	// -------------------------------------------------
	task automatic t_reset();
		logic [7:0] v;
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), v);
			check(v, 8'h00);
		end
		check({7'h00, irq_o}, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_gate();
		logic [7:0] v;
		pins.gate(0, 1'b0);
		pins.gate(1, 1'b0);
		load0(8'h09, 8'h55, 8'h00);
		wr(dual_timer_pkg::ADDR_CTRL, 8'h10);
		repeat (40) @(posedge sys_clk_i);
		rd(dual_timer_pkg::ADDR_LOW0, v);
		check(v, 8'h55);
		rd(dual_timer_pkg::ADDR_IRQ_ST, v);
		check(v & 8'h0C, 8'h0C);
		pins.gate(0, 1'b1);
		pins.gate(1, 1'b1);
		repeat (40) @(posedge sys_clk_i);
		rd(dual_timer_pkg::ADDR_LOW0, v);
		check_in(v, 8'h56, 8'h5A);
		$display("test gate done");
	endtask
	task automatic t_ovf16();
		logic [7:0] v;
		load0(8'h01, 8'hFE, 8'hFF);
		rd(dual_timer_pkg::ADDR_IRQ_ST, v);
		wr(dual_timer_pkg::ADDR_IRQ_MSK, 8'h01);
		wr(dual_timer_pkg::ADDR_CTRL, 8'h10);
		wait_flag(dual_timer_pkg::CTRL_OVF0);
		wr(dual_timer_pkg::ADDR_CTRL, 8'h00);
		rd(dual_timer_pkg::ADDR_HIGH0, v);
		check(v, 8'h00);
		check({7'h00, irq_o}, 8'h01);
		rd(dual_timer_pkg::ADDR_IRQ_ST, v);
		check(v & 8'h01, 8'h01);
		check({7'h00, irq_o}, 8'h00);
		$display("test overflow16 done");
	endtask
	task automatic t_ovf13();
		logic [7:0] v;
		load0(8'h00, 8'hFE, 8'hFF);
		wr(dual_timer_pkg::ADDR_CTRL, 8'h10);
		wait_flag(dual_timer_pkg::CTRL_OVF0);
		wr(dual_timer_pkg::ADDR_CTRL, 8'h00);
		rd(dual_timer_pkg::ADDR_HIGH0, v);
		check(v, 8'h00);
		rd(dual_timer_pkg::ADDR_LOW0, v);
		check_in(v & 8'h1F, 0, 1);
		$display("test overflow13 done");
	endtask
	task automatic t_reload();
		logic [7:0] v;
		load0(8'h02, 8'hFE, 8'hA0);
		wr(dual_timer_pkg::ADDR_CTRL, 8'h10);
		wait_flag(dual_timer_pkg::CTRL_OVF0);
		wr(dual_timer_pkg::ADDR_CTRL, 8'h00);
		rd(dual_timer_pkg::ADDR_HIGH0, v);
		check(v, 8'hA0);
		rd(dual_timer_pkg::ADDR_LOW0, v);
		check_in(v, 8'hA0, 8'hA1);
		$display("test reload done");
	endtask
	task automatic t_split();
		logic [7:0] v;
		load0(8'h03, 8'h00, 8'hFE);
		wr(dual_timer_pkg::ADDR_CTRL, 8'h40);
		wait_flag(dual_timer_pkg::CTRL_OVF1);
		wr(dual_timer_pkg::ADDR_CTRL, 8'h00);
		rd(dual_timer_pkg::ADDR_LOW0, v);
		check(v, 8'h00);
		rd(dual_timer_pkg::ADDR_HIGH0, v);
		check_in(v, 0, 1);
		$display("test split done");
	endtask
	task automatic t_timer1();
		logic [7:0] v;
		for (int m = 2; m < 4; m++) begin
			wr(dual_timer_pkg::ADDR_MODE, 8'(m << 4));
			wr(dual_timer_pkg::ADDR_LOW1, 8'h10);
			wr(dual_timer_pkg::ADDR_CTRL, 8'h40);
			repeat (60) @(posedge sys_clk_i);
			rd(dual_timer_pkg::ADDR_LOW1, v);
			check(v, 8'h10);
		end
		wr(dual_timer_pkg::ADDR_CTRL, 8'h00);
		wr(dual_timer_pkg::ADDR_MODE, 8'h10);
		wr(dual_timer_pkg::ADDR_LOW1, 8'hFE);
		wr(dual_timer_pkg::ADDR_HIGH1, 8'hFF);
		baud_count = 0;
		wr(dual_timer_pkg::ADDR_CTRL, 8'h40);
		wait_flag(dual_timer_pkg::CTRL_OVF1);
		wr(dual_timer_pkg::ADDR_CTRL, 8'h00);
		check(8'(baud_count), 8'h01);
		$display("test timer1 done");
	endtask
	task automatic t_counter();
		logic [7:0] v;
		load0(8'h55, 8'h00, 8'h00);
		wr(dual_timer_pkg::ADDR_LOW1, 8'h00);
		wr(dual_timer_pkg::ADDR_CTRL, 8'h50);
		repeat (60) @(posedge sys_clk_i);
		rd(dual_timer_pkg::ADDR_LOW0, v);
		check(v, 8'h00);
		fork
			pins.pulses(0, 3);
			pins.pulses(1, 2);
		join
		repeat (40) @(posedge sys_clk_i);
		rd(dual_timer_pkg::ADDR_LOW0, v);
		check(v, 8'h03);
		rd(dual_timer_pkg::ADDR_LOW1, v);
		check(v, 8'h02);
		$display("test counter done");
	endtask
	task automatic t_rate();
		logic [7:0] v;
		int         exp;
		for (int f = 0; f < 2; f++) begin
			@(posedge sys_clk_i);
			fast_tick_i <= 1'(f);
			exp = 120 / (f == 1 ? 6 : 12);
			load0(8'h01, 8'h00, 8'h00);
			wr(dual_timer_pkg::ADDR_CTRL, 8'h10);
			repeat (120) @(posedge sys_clk_i);
			wr(dual_timer_pkg::ADDR_CTRL, 8'h00);
			rd(dual_timer_pkg::ADDR_LOW0, v);
			check_in(v, exp - 1, exp + 1);
		end
		$display("test rate done");
	endtask
	// -------------------------------------------------
	// main sequence
	// -------------------------------------------------
	initial begin
		mismatches  = 0;
		check_count = 0;
		baud_count  = 0;
		reset_i     = 1'b1;
		reg_addr_i  = 3'h0;
		reg_wdata_i = 8'h00;
		reg_wr_i    = 1'b0;
		reg_rd_i    = 1'b0;
		fast_tick_i = 1'b0;
		repeat (10) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_gate();
		t_ovf16();
		t_ovf13();
		t_reload();
		t_split();
		t_timer1();
		t_counter();
		t_rate();
		complete_run();
	end
endmodule
`default_nettype wire
